// >>> common/nbx_cfg.svh
// Constants for the nibble core arithmetic and transfer-of-control executor
// Assumes inclusion by the package and by the stack and executor design files
`ifndef NBX_CFG_SVH
`define NBX_CFG_SVH
`define NBX_OP_ZERO_ACC 8'h00
`define NBX_OP_CSUM_SKIP 8'h10
`define NBX_OP_XOR 8'h02
`define NBX_OP_SET_CARRY 8'h22
`define NBX_OP_SUM_CSKIP 8'h30
`define NBX_OP_ADD 8'h31
`define NBX_OP_CLR_CARRY 8'h32
`define NBX_OP_COMP 8'h40
`define NBX_OP_NOP 8'h44
`define NBX_OP_POP 8'h48
`define NBX_OP_POP_SKIP 8'h49
`define NBX_OP_PLUS_TEN 8'h4a
`define NBX_OP_IND_JUMP 8'hff
`define NBX_HI_IMM 4'h5
`define NBX_HI_LONG 4'h6
`define NBX_LONG_JUMP_SEL 2'h0
`define NBX_LONG_CALL_SEL 2'h2
`define NBX_TEN 4'ha
`define NBX_CALL_PAGE 4'h2
`define NBX_PC_RESET 10'h000
`define NBX_ACC_RESET 4'h0
`define NBX_PTR_RESET 6'h00
`define NBX_PC_ONE 10'h001
`define NBX_SUB_PAGES 3'h1
`define NBX_IMM_NONE 4'h0
`endif

// >>> common/nbx_pkg.sv
// Types shared by the nibble core executor files
// Assumes nbx_cfg.svh is on the include path
`include "nbx_cfg.svh"
package nbx_pkg;
	typedef enum logic [1:0]
	{
		NBX_EXEC = 2'h0,
		NBX_SECOND = 2'h1,
		NBX_IND_WAIT = 2'h2
	} nbx_state_t;
	typedef struct packed
	{
		logic [3:0] sum;
		logic carry;
	} nbx_sum_t;
	typedef struct packed
	{
		logic [1:0] ram_row_select;
		logic [3:0] ram_digit_select;
	} nbx_ptr_t;
endpackage

// >>> logic/nbx_adder.sv
// Four-bit adder with carry in and carry out
// Assumes purely combinational use by the executor
`timescale 1ns/1ps
`default_nettype none
module nbx_adder
	import nbx_pkg::*;
(
	input wire logic [3:0] a,
	input wire logic [3:0] b,
	input wire logic cin,
	output nbx_sum_t res
);
	logic [4:0] full;
	// Modulo sixteen sum, carry means total above fifteen
	assign full = {1'b0, a} + {1'b0, b} + {4'h0, cin};
	assign res = {full[3:0], full[4]};
endmodule
`default_nettype wire

// >>> logic/nbx_stack.sv
// Three-level return stack of ten-bit program addresses
// Assumes push and pop never asserted together
`timescale 1ns/1ps
`default_nettype none
`include "nbx_cfg.svh"
module nbx_stack
	import nbx_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic push,
	input wire logic pop,
	input wire logic [9:0] push_addr,
	output logic [9:0] top
);
	logic [9:0] return_stack_top_ff;
	logic [9:0] return_stack_mid_ff;
	logic [9:0] return_stack_bottom_ff;
	// Push shifts down and drops bottom, pop shifts up
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			return_stack_top_ff <= `NBX_PC_RESET;
			return_stack_mid_ff <= `NBX_PC_RESET;
			return_stack_bottom_ff <= `NBX_PC_RESET;
		end
		else if (push)
		begin
			return_stack_top_ff <= push_addr;
			return_stack_mid_ff <= return_stack_top_ff;
			return_stack_bottom_ff <= return_stack_mid_ff;
		end
		else if (pop)
		begin
			return_stack_top_ff <= return_stack_mid_ff;
			return_stack_mid_ff <= return_stack_bottom_ff;
		end
	end
	assign top = return_stack_top_ff;
endmodule
`default_nettype wire

// >>> logic/nbx_exec.sv
// Executor for arithmetic and transfer-of-control opcodes of a nibble core
// Assumes ROM and RAM answer combinationally in the same cycle
// Functional notes
// - sum_carry_skip adds A, carry, RAM; skip
// - Add, plus_ten, complement touch only A
// - plus_immediate_skip adds y, skips, carry kept
// - complement_sum_skip: not A plus RAM plus carry
// - Exclusive-or replaces A, no skip
// - clear_carry, set_carry_flag, no-op never skip
// - indirect_jump loads PC low byte from ROM
// - long_jump two bytes, full ten-bit target
// - page_jump seven or six low bits
// - call_page_two pushes, page 0010, six bits
// - long_call pushes incremented PC, full target
// - Push shifts stack down, bottom lost
// - pop_and_resume pops stack into PC
// - pop_resume_skip pops then always skips
// - Six-bit RAM pointer: row and digit
// - Ten-bit PC, four-bit A and RAM
// - Reset clears PC, A, pointer, carry
`timescale 1ns/1ps
`default_nettype none
`include "nbx_cfg.svh"
module nbx_exec
	import nbx_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	output logic [9:0] rom_addr,
	input wire logic [7:0] rom_data,
	output nbx_ptr_t ram_ptr,
	input wire logic [3:0] ram_data,
	output logic [9:0] program_counter,
	output logic [3:0] acc,
	output logic carry,
	output logic skip_pending
);
	// ===========================================================
	// State and datapath signals
	nbx_state_t state_ff;
	nbx_state_t nxt_state;
	logic [9:0] program_counter_ff;
	logic [9:0] nxt_program_counter;
	logic [3:0] acc_ff;
	logic [3:0] nxt_acc;
	logic carry_ff;
	logic nxt_carry;
	logic skip_ff;
	logic nxt_skip;
	nbx_ptr_t ptr_ff;
	logic [7:0] first_ff;
	logic [7:0] nxt_first;
	logic squash_ff;
	logic nxt_squash;
	logic push;
	logic pop;
	logic [9:0] stack_top;
	logic [9:0] pc_inc;
	logic [3:0] add_a;
	logic [3:0] add_b;
	logic add_cin;
	nbx_sum_t add_res;
	logic [7:0] op;
	logic live;
	assign pc_inc = program_counter_ff + `NBX_PC_ONE;
	assign op = rom_data;
	assign live = !skip_ff;
	// ===========================================================
	// Shared adder
	nbx_adder u_adder
	(
		.a(add_a),
		.b(add_b),
		.cin(add_cin),
		.res(add_res)
	);
	// Operand selection for the adder
	always_comb
	begin
		add_a = acc_ff;
		add_b = ram_data;
		add_cin = 1'b0;
		if (op == `NBX_OP_SUM_CSKIP)
			add_cin = carry_ff;
		else if (op == `NBX_OP_CSUM_SKIP)
		begin
			add_a = ~acc_ff;
			add_cin = carry_ff;
		end
		else if (op == `NBX_OP_PLUS_TEN)
			add_b = `NBX_TEN;
		else if (op[7:4] == `NBX_HI_IMM)
			add_b = op[3:0];
	end
	// ===========================================================
	// Return stack
	nbx_stack u_stack
	(
		.clock(clock),
		.reset_n(reset_n),
		.push(push),
		.pop(pop),
		.push_addr(pc_inc),
		.top(stack_top)
	);
	// ===========================================================
	// Decode and next-state logic
	always_comb
	begin
		nxt_state = state_ff;
		nxt_program_counter = pc_inc;
		nxt_acc = acc_ff;
		nxt_carry = carry_ff;
		nxt_skip = 1'b0;
		nxt_first = first_ff;
		nxt_squash = squash_ff;
		push = 1'b0;
		pop = 1'b0;
		unique case (state_ff)
			NBX_EXEC:
			begin
				if (op[7:4] == `NBX_HI_LONG &&
					(op[3:2] == `NBX_LONG_JUMP_SEL ||
					op[3:2] == `NBX_LONG_CALL_SEL))
				begin
					// Two-byte opcode, operand byte follows
					nxt_first = op;
					nxt_squash = skip_ff;
					nxt_state = NBX_SECOND;
				end
				else if (op == `NBX_OP_IND_JUMP)
				begin
					nxt_squash = skip_ff;
					if (live)
						nxt_state = NBX_IND_WAIT;
				end
				else if (live)
				begin
					if (op == `NBX_OP_SUM_CSKIP ||
						op == `NBX_OP_CSUM_SKIP)
					begin
						nxt_acc = add_res.sum;
						nxt_carry = add_res.carry;
						nxt_skip = add_res.carry;
					end
					else if (op == `NBX_OP_ADD ||
						op == `NBX_OP_PLUS_TEN)
						nxt_acc = add_res.sum;
					else if (op == `NBX_OP_COMP)
						nxt_acc = ~acc_ff;
					else if (op == `NBX_OP_ZERO_ACC)
						nxt_acc = `NBX_ACC_RESET;
					else if (op[7:4] == `NBX_HI_IMM &&
						op[3:0] != `NBX_IMM_NONE)
					begin
						nxt_acc = add_res.sum;
						nxt_skip = add_res.carry;
					end
					else if (op == `NBX_OP_XOR)
						nxt_acc = acc_ff ^ ram_data;
					else if (op == `NBX_OP_CLR_CARRY)
						nxt_carry = 1'b0;
					else if (op == `NBX_OP_SET_CARRY)
						nxt_carry = 1'b1;
					else if (op == `NBX_OP_POP ||
						op == `NBX_OP_POP_SKIP)
					begin
						pop = 1'b1;
						nxt_program_counter = stack_top;
						nxt_skip = op[0];
					end
					else if (op[7])
					begin
						if (op[6] == 1'b0 &&
							program_counter_ff[9:7] == `NBX_SUB_PAGES)
						begin
							// Pages 2 and 3 take page_jump instead
							nxt_program_counter = {program_counter_ff[9:7],
								op[6:0]};
						end
						else if (op[6] == 1'b0)
						begin
							push = 1'b1;
							nxt_program_counter = {`NBX_CALL_PAGE, op[5:0]};
						end
						else if (program_counter_ff[9:7] == `NBX_SUB_PAGES)
							nxt_program_counter = {program_counter_ff[9:7],
								op[6:0]};
						else
							nxt_program_counter = {program_counter_ff[9:6],
								op[5:0]};
					end
				end
			end
			NBX_SECOND:
			begin
				nxt_state = NBX_EXEC;
				if (!squash_ff)
				begin
					nxt_program_counter = {first_ff[1:0], op};
					push = (first_ff[3:2] == `NBX_LONG_CALL_SEL);
				end
			end
			NBX_IND_WAIT:
			begin
				nxt_state = NBX_EXEC;
				nxt_program_counter = {program_counter_ff[9:8], op};
			end
			default:
				nxt_state = NBX_EXEC;
		endcase
	end
	// ROM address: indirect table lookup uses A and RAM
	always_comb
	begin
		if (state_ff == NBX_IND_WAIT)
			rom_addr = {program_counter_ff[9:8], acc_ff, ram_data};
		else
			rom_addr = program_counter_ff;
	end
	// ===========================================================
	// Sequencer state and program counter
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_ff <= NBX_EXEC;
			program_counter_ff <= `NBX_PC_RESET;
			first_ff <= 8'h00;
			squash_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			first_ff <= nxt_first;
			squash_ff <= nxt_squash;
			if (state_ff == NBX_IND_WAIT || nxt_state != NBX_IND_WAIT)
				program_counter_ff <= nxt_program_counter;
		end
	end
	// Accumulator, carry and skip flag
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			acc_ff <= `NBX_ACC_RESET;
			carry_ff <= 1'b0;
			skip_ff <= 1'b0;
		end
		else
		begin
			acc_ff <= nxt_acc;
			carry_ff <= nxt_carry;
			if (state_ff == NBX_EXEC)
				skip_ff <= nxt_skip;
		end
	end
	// RAM pointer, held since no opcode here writes it
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			ptr_ff <= `NBX_PTR_RESET;
		else
			ptr_ff <= ptr_ff;
	end
	assign ram_ptr = ptr_ff;
	assign program_counter = program_counter_ff;
	assign acc = acc_ff;
	assign carry = carry_ff;
	assign skip_pending = skip_ff;
	// ===========================================================
	// Checks
	property p_sum_skip;
		@(posedge clock) disable iff (!reset_n)
		(state_ff == NBX_EXEC && live && op == `NBX_OP_SUM_CSKIP)
		|=> (skip_ff == $past(add_res.carry) && carry_ff == skip_ff);
	endproperty
	a_sum_skip: assert property (p_sum_skip) else $error("sum skip bad");
	property p_imm_keeps_carry;
		@(posedge clock) disable iff (!reset_n)
		(state_ff == NBX_EXEC && live && op[7:4] == `NBX_HI_IMM)
		|=> $stable(carry_ff);
	endproperty
	a_imm_keeps_carry: assert property (p_imm_keeps_carry) else $error("imm carry");
	property p_xor;
		@(posedge clock) disable iff (!reset_n)
		(state_ff == NBX_EXEC && live && op == `NBX_OP_XOR)
		|=> acc_ff == ($past(acc_ff) ^ $past(ram_data)) && !skip_ff;
	endproperty
	a_xor: assert property (p_xor) else $error("xor result");
	property p_set_carry;
		@(posedge clock) disable iff (!reset_n)
		(state_ff == NBX_EXEC && live && op == `NBX_OP_SET_CARRY)
		|=> carry_ff && !skip_ff;
	endproperty
	a_set_carry: assert property (p_set_carry) else $error("set carry");
	property p_pop_skip;
		@(posedge clock) disable iff (!reset_n)
		(state_ff == NBX_EXEC && live && op == `NBX_OP_POP_SKIP)
		|=> skip_ff && program_counter_ff == $past(stack_top);
	endproperty
	a_pop_skip: assert property (p_pop_skip) else $error("pop skip");
	property p_long_target;
		@(posedge clock) disable iff (!reset_n)
		(state_ff == NBX_SECOND && !squash_ff)
		|=> program_counter_ff == {$past(first_ff[1:0]), $past(op)};
	endproperty
	a_long_target: assert property (p_long_target) else $error("long target");
	property p_call_page;
		@(posedge clock) disable iff (!reset_n)
		(state_ff == NBX_EXEC && live && op[7:6] == 2'h2 &&
		program_counter_ff[9:7] != `NBX_SUB_PAGES)
		|=> program_counter_ff[9:6] == `NBX_CALL_PAGE && stack_top == $past(pc_inc);
	endproperty
	a_call_page: assert property (p_call_page) else $error("call page");
	property p_skip_inert;
		@(posedge clock) disable iff (!reset_n)
		(state_ff == NBX_EXEC && skip_ff && op[7:4] != `NBX_HI_LONG)
		|=> $stable(acc_ff) && $stable(carry_ff);
	endproperty
	a_skip_inert: assert property (p_skip_inert) else $error("skip acted");
endmodule
`default_nettype wire

// >>> testbench/nbx_mem_model.sv
// Behavioural program ROM and data RAM facing the nibble core executor
// Assumes the bench loads both arrays by hierarchical writes while in reset
`timescale 1ns/1ps
`default_nettype none
module nbx_mem_model
	import nbx_pkg::*;
(
	input wire logic [9:0] rom_addr,
	output logic [7:0] rom_data,
	input wire nbx_ptr_t ram_ptr,
	output logic [3:0] ram_data
);
	// ======================================
	// Storage
	logic [7:0] rom [0:1023];
	logic [3:0] ram [0:63];

	// Both memories answer in the same cycle, row and digit form the index
	assign rom_data = rom[rom_addr];
	assign ram_data = ram[{ram_ptr.ram_row_select, ram_ptr.ram_digit_select}];
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench for the nibble core executor
// Assumes the executor and nbx_mem_model; programs end in a self jump
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import nbx_pkg::*;
;
	typedef struct {logic [9:0] pc; logic [3:0] acc; logic c;
		logic sk;} nbx_exp_t;
	logic clock;
	logic reset_n;
	logic [9:0] rom_addr;
	logic [7:0] rom_data;
	nbx_ptr_t ram_ptr;
	logic [3:0] ram_data;
	logic [9:0] program_counter;
	logic [3:0] acc;
	logic carry;
	logic skip_pending;
	int err_total;
	int n_compared;
	nbx_exp_t q[$];
	nbx_exp_t got;
	logic [7:0] ops [0:10];
	logic [7:0] op;
	logic [7:0] d;
	logic [3:0] a;
	logic [3:0] m;
	logic [3:0] na;
	logic [4:0] s;
	logic [9:0] t;
	logic c;
	logic nc;
	logic sk;
	int unsigned seed;

	// ======================================
	// Design and memories
	nbx_exec i_nbx_exec (.clock(clock), .reset_n(reset_n),
		.rom_addr(rom_addr), .rom_data(rom_data), .ram_ptr(ram_ptr),
		.ram_data(ram_data), .program_counter(program_counter), .acc(acc),
		.carry(carry), .skip_pending(skip_pending));
	nbx_mem_model i_nbx_mem_model (.rom_addr(rom_addr),
		.rom_data(rom_data), .ram_ptr(ram_ptr), .ram_data(ram_data));

	// Clock at 40 MHz
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// ======================================
	// Helpers
	task automatic cmp(input logic [9:0] g, input logic [9:0] e);
		n_compared++;
		if (g !== e)
		begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [9:0] ad, input logic [7:0] b);
		i_nbx_mem_model.rom[ad] = b;
	endtask

	// Self jump byte for an address, seven bits in pages 2 and 3
	function automatic logic [7:0] loopb(input logic [9:0] ad);
		return (ad[9:7] == 3'h1) ? {1'b1, ad[6:0]} : {2'h3, ad[5:0]};
	endfunction

	// Reset for five cycles, check cleared state, fill ROM with no-ops
	task automatic start();
		reset_n = 1'b0;
		repeat (5) @(negedge clock);
		cmp(program_counter, 10'h000);
		cmp({6'h00, acc}, 10'h000);
		cmp({9'h000, carry}, 10'h000);
		cmp({4'h0, ram_ptr}, 10'h000);
		for (int i = 0; i < 1024; i++)
			wr(i[9:0], 8'h44);
	endtask

	// Note expected end state, release reset, wait for the monitor
	task automatic go(input logic [9:0] pc, input logic [3:0] ea,
		input logic ec);
		q.push_back('{pc, ea, ec, 1'b0});
		reset_n = 1'b1;
		for (int k = 0; k < 300 && q.size() > 0; k++)
			@(negedge clock);
		if (q.size() > 0)
		begin
			err_total++;
			$display("wrong value at %0t: end %h not reached", $time, pc);
			q.delete();
		end
	endtask

	task automatic tally_and_finish();
		if (err_total == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Monitor: compare once the program reaches its end address
	always @(negedge clock)
	begin
		if (q.size() > 0 && program_counter === q[0].pc)
		begin
			got = q.pop_front();
			cmp({6'h00, acc}, {6'h00, got.acc});
			cmp({9'h000, carry}, {9'h000, got.c});
			cmp({9'h000, skip_pending}, {9'h000, got.sk});
		end
	end

	// Watchdog well beyond the expected run length
	initial
	begin
		#2000000;
		err_total++;
		tally_and_finish();
	end

	// ======================================
	// Tests
	initial
	begin
		reset_n = 1'b0;
		err_total = 0;
		n_compared = 0;
		seed = $urandom(60854);
		ops = '{8'h30, 8'h31, 8'h4a, 8'h10, 8'h00, 8'h02, 8'h32, 8'h22,
			8'h44, 8'h40, 8'h50};
		// Arithmetic ops with a complement after them to expose skips
		for (int r = 0; r < 4; r++)
			for (int j = 0; j < 11; j++)
			begin
				a = $urandom;
				m = $urandom;
				c = $urandom;
				op = (j == 10) ? 8'h50 | (8'h01 + $urandom % 15) : ops[j];
				start();
				i_nbx_mem_model.ram[0] = m;
				wr(0, 8'h00);
				wr(1, (a != 4'h0) ? {4'h5, a} : 8'h44);
				wr(2, c ? 8'h22 : 8'h32);
				wr(3, op);
				wr(4, 8'h40);
				wr(5, 8'hc5);
				na = a;
				nc = c;
				sk = 1'b0;
				case ((op[7:4] == 4'h5) ? 8'h50 : op)
					8'h30: s = a + c + m;
					8'h31: na = a + m;
					8'h4a: na = a + 4'ha;
					8'h10: s = {1'b0, ~a} + m + c;
					8'h00: na = 4'h0;
					8'h02: na = a ^ m;
					8'h32: nc = 1'b0;
					8'h22: nc = 1'b1;
					8'h40: na = ~a;
					8'h50: s = a + op[3:0];
					default: ;
				endcase
				if (op == 8'h30 || op == 8'h10 || op[7:4] == 4'h5)
				begin
					na = s[3:0];
					sk = s[4];
					nc = (op[7:4] == 4'h5) ? c : s[4];
				end
				// State right after the op, with the skip still pending
				q.push_back('{10'h004, na, nc, sk});
				go(10'h005, sk ? na : ~na, nc);
			end
		// Skipped long jump must consume both bytes
		start();
		wr(0, 8'h00);
		wr(1, 8'h5f);
		wr(2, 8'h51);
		wr(3, 8'h62);
		wr(4, 8'h40);
		wr(5, 8'hc5);
		go(10'h005, 4'h0, 1'b0);
		// Long jumps to six random targets between 10 and 1023
		for (int r = 0; r < 6; r++)
		begin
			t = 10'h00a + $urandom % 1014;
			start();
			wr(0, {6'h18, t[9:8]});
			wr(1, t[7:0]);
			wr(t, loopb(t));
			go(t, 4'h0, 1'b0);
		end
		// Long call then return, plain and with skip
		for (int r = 0; r < 2; r++)
		begin
			t = 10'h100 + $urandom % 768;
			start();
			wr(0, {6'h1a, t[9:8]});
			wr(1, t[7:0]);
			wr(t, r ? 8'h49 : 8'h48);
			wr(2, 8'h40);
			wr(3, 8'hc3);
			go(10'h003, r ? 4'h0 : 4'hf, 1'b0);
		end
		// Page call into page two and return
		d = $urandom % 63;
		start();
		wr(0, {2'h2, d[5:0]});
		wr({4'h2, d[5:0]}, 8'h40);
		wr({4'h2, d[5:0]} + 10'h001, 8'h48);
		wr(1, 8'hc1);
		go(10'h001, 4'hf, 1'b0);
		// Four nested calls, three returns unwind in order
		start();
		for (int i = 0; i < 4; i++)
		begin
			wr(10'(16 * i), 8'h68);
			wr(10'(16 * i + 1), 8'(16 * i + 16));
		end
		wr(10'h040, 8'h48);
		wr(10'h032, 8'h48);
		wr(10'h022, 8'h48);
		wr(10'h012, 8'hd2);
		go(10'h012, 4'h0, 1'b0);
		// Indirect jump through the word at {acc, RAM}
		for (int r = 0; r < 4; r++)
		begin
			a = 4'h1 + $urandom % 15;
			m = $urandom;
			d = 8'h10 + $urandom % 240;
			if (d == {a, m})
				d = d ^ 8'h01;
			start();
			i_nbx_mem_model.ram[0] = m;
			wr(0, 8'h00);
			wr(1, {4'h5, a});
			wr(2, 8'hff);
			wr({2'h0, a, m}, d);
			wr({2'h0, d}, loopb({2'h0, d}));
			go({2'h0, d}, a, 1'b0);
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
